// ---- design/bulk_byte_port.sv ----
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module bulk_byte_port (
    // Clock, reset, enable
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_CLK_EN,
    // AHB-Lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    // Host pins
    input  wire logic        I_INPUT_PORT_CLOCK,
    input  wire logic        I_OUTPUT_PORT_CLOCK,
    input  wire logic        I_INPUT_QUALIFIER,
    input  wire logic        I_OUTPUT_QUALIFIER,
    input  wire logic [7:0]  I_INPUT_BYTE_BUS,
    output logic      [7:0]  O_INPUT_BYTE_BUS,
    output logic             O_INPUT_BYTE_BUS_OE,
    input  wire logic [2:0]  I_INPUT_FORMAT_BUS,
    output logic      [2:0]  O_INPUT_FORMAT_BUS,
    output logic             O_INPUT_FORMAT_BUS_OE,
    output logic      [7:0]  O_RECEIVE_BYTE_BUS,
    output logic      [2:0]  O_OUTPUT_FORMAT_BUS,
    output logic             O_WRITE_FULL_FLAG,
    output logic             O_DATA_AVAILABLE_FLAG,
    output logic             O_STATUS_PIN_ZERO,
    output logic             O_STATUS_PIN_THREE,
    // Transmit FIFO side
    output logic             O_TX_WR,
    output logic      [31:0] O_TX_QUAD,
    output logic      [11:0] O_TX_FMT,
    input  wire logic        I_TX_FULL,
    // Receive FIFO side
    input  wire logic        I_RX_VALID,
    input  wire logic [31:0] I_RX_QUAD,
    input  wire logic [11:0] I_RX_FMT,
    output logic             O_RX_POP
);

    // --------------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------------
    logic [bulk_port_pkg::SYNC_W-1:0] pins_s;
    logic       iclk_s;
    logic       oclk_s;
    logic       iq_s;
    logic       oq_s;
    logic [7:0] ibyte_s;
    logic [2:0] ifmt_s;
    logic       iclk_prev_q;
    logic       oclk_prev_q;

    pin_sync #(.W(bulk_port_pkg::SYNC_W)) u_sync (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_en    (I_CLK_EN),
        .i_d     ({I_INPUT_PORT_CLOCK, I_OUTPUT_PORT_CLOCK,
                   I_INPUT_QUALIFIER, I_OUTPUT_QUALIFIER,
                   I_INPUT_BYTE_BUS, I_INPUT_FORMAT_BUS}),
        .o_q     (pins_s)
    );

    assign {iclk_s, oclk_s, iq_s, oq_s, ibyte_s, ifmt_s} = pins_s;

    wire in_rise  = iclk_s && !iclk_prev_q;
    wire out_rise = oclk_s && !oclk_prev_q;

    // --------------------------------------------------------------------
    // Registers and mode decode
    // --------------------------------------------------------------------
    logic [5:0]  ctrl_q;
    logic [1:0]  route_q;
    logic        half_q;
    logic [7:0]  dph_addr_q;
    logic        dph_wr_q;
    logic [31:0] rdata_q;
    bulk_port_pkg::mode_e mode;

    wire [2:0] imode = ctrl_q[bulk_port_pkg::CTRL_IMODE +: 3];
    wire [1:0] omode = ctrl_q[bulk_port_pkg::CTRL_OMODE +: 2];

    assign mode =
        (imode == bulk_port_pkg::IMODE_AB && omode == bulk_port_pkg::OMODE_A)
            ? bulk_port_pkg::MODE_A :
        (imode == bulk_port_pkg::IMODE_AB && omode == bulk_port_pkg::OMODE_B)
            ? bulk_port_pkg::MODE_B :
        (imode == bulk_port_pkg::IMODE_C && omode == bulk_port_pkg::OMODE_C)
            ? bulk_port_pkg::MODE_C :
        (imode == bulk_port_pkg::IMODE_D && omode == bulk_port_pkg::OMODE_D)
            ? bulk_port_pkg::MODE_D : bulk_port_pkg::MODE_OFF;

    wire mode_ab = mode == bulk_port_pkg::MODE_A
                || mode == bulk_port_pkg::MODE_B;
    wire mode_c  = mode == bulk_port_pkg::MODE_C;
    wire mode_d  = mode == bulk_port_pkg::MODE_D;

    // --------------------------------------------------------------------
    // Write path: pack bytes into quadlets
    // --------------------------------------------------------------------
    logic [1:0]  wcnt_q;
    logic [23:0] wquad_q;
    logic [8:0]  wfmt_q;
    logic        wfull_q;
    logic        tx_have_q;
    logic [2:0]  wgap_q;
    logic        iq_edge_q;
    logic [31:0] tx_quad_q;
    logic [11:0] tx_fmt_q;

    // Mode C accepts one byte per qualifier assertion, spaced out.
    wire wr_c_ok = mode_c && !iq_edge_q
                && wgap_q >= bulk_port_pkg::GAP_EDGES;
    wire wr_req  = in_rise && iq_s
                && (mode_ab || wr_c_ok || (mode_d && !oq_s));
    wire wr_take = wr_req && !wfull_q;
    wire wr_done = wr_take && wcnt_q == bulk_port_pkg::BYTE_LAST;

    // Mode C only carries cells, so the top format bit picks first byte.
    wire [2:0] wr_fmt = mode_c ? (ifmt_s[2] ? bulk_port_pkg::FMT_FIRST
                                            : bulk_port_pkg::FMT_CELL)
                               : ifmt_s;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wcnt_q  <= 2'h0;
            wquad_q <= 24'h0;
            wfmt_q  <= 9'h0;
        end else if (I_CLK_EN && wr_take) begin
            wcnt_q  <= wcnt_q + 2'h1;
            wquad_q <= {ibyte_s, wquad_q[23:8]};
            wfmt_q  <= {wr_fmt, wfmt_q[8:3]};
        end
    end

    // The flag only moves between quadlets, so a started quadlet always
    // finds room: the FIFO had a slot when its first byte came in.
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wfull_q <= 1'b0;
        end else if (I_CLK_EN && wcnt_q == 2'h0 && !wr_take) begin
            wfull_q <= I_TX_FULL || tx_have_q;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            tx_have_q <= 1'b0;
            tx_quad_q <= 32'h0;
            tx_fmt_q  <= 12'h0;
        end else if (I_CLK_EN) begin
            if (wr_done) begin
                tx_have_q <= 1'b1;
                tx_quad_q <= {ibyte_s, wquad_q};
                tx_fmt_q  <= {wr_fmt, wfmt_q};
            end else if (O_TX_WR) begin
                tx_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wgap_q    <= bulk_port_pkg::GAP_EDGES;
            iq_edge_q <= 1'b0;
        end else if (I_CLK_EN && in_rise) begin
            iq_edge_q <= iq_s;
            if (wr_take) begin
                wgap_q <= 3'h0;
            end else if (wgap_q < bulk_port_pkg::GAP_EDGES) begin
                wgap_q <= wgap_q + 3'h1;
            end
        end
    end

    assign O_TX_WR   = I_CLK_EN && tx_have_q && !I_TX_FULL;
    assign O_TX_QUAD = tx_quad_q;
    assign O_TX_FMT  = tx_fmt_q;
    assign O_WRITE_FULL_FLAG = wfull_q && !mode_c;

    // --------------------------------------------------------------------
    // Read path: unpack quadlets from the holding register
    // --------------------------------------------------------------------
    logic        hold_q;
    logic [31:0] rx_quad_q;
    logic [11:0] rx_fmt_q;
    logic [1:0]  rcnt_q;
    logic [2:0]  rgap_q;
    logic        oq_edge_q;
    logic [7:0]  out_byte_q;
    logic [2:0]  out_fmt_q;

    // Mode B reads with no qualifier: the host must keep pace or lose data.
    wire rd_a   = mode == bulk_port_pkg::MODE_A
               && out_rise && oq_s;
    wire rd_b   = mode == bulk_port_pkg::MODE_B && out_rise;
    wire rd_c   = mode_c && out_rise && oq_s && !oq_edge_q
               && rgap_q >= bulk_port_pkg::GAP_EDGES;
    wire rd_d   = mode_d && in_rise && iq_s && oq_s;
    wire rd_take = hold_q && (rd_a || rd_b || rd_c || rd_d);
    wire rd_last = rd_take && rcnt_q == bulk_port_pkg::BYTE_LAST;

    assign O_RX_POP = I_CLK_EN && I_RX_VALID && !hold_q;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            hold_q    <= 1'b0;
            rx_quad_q <= 32'h0;
            rx_fmt_q  <= 12'h0;
            rcnt_q    <= 2'h0;
        end else if (I_CLK_EN) begin
            if (O_RX_POP) begin
                hold_q    <= 1'b1;
                rx_quad_q <= I_RX_QUAD;
                rx_fmt_q  <= I_RX_FMT;
                rcnt_q    <= 2'h0;
            end else if (rd_take) begin
                hold_q    <= !rd_last;
                rx_quad_q <= {8'h00, rx_quad_q[31:8]};
                rx_fmt_q  <= {3'h0, rx_fmt_q[11:3]};
                rcnt_q    <= rcnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rgap_q    <= bulk_port_pkg::GAP_EDGES;
            oq_edge_q <= 1'b0;
        end else if (I_CLK_EN && out_rise) begin
            oq_edge_q <= oq_s;
            if (rd_take) begin
                rgap_q <= 3'h0;
            end else if (rgap_q < bulk_port_pkg::GAP_EDGES) begin
                rgap_q <= rgap_q + 3'h1;
            end
        end
    end

    // The head byte always stands on the bus; idle shows when none waits.
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            out_byte_q <= 8'h00;
            out_fmt_q  <= bulk_port_pkg::FMT_IDLE;
        end else if (I_CLK_EN) begin
            out_byte_q <= hold_q ? rx_quad_q[7:0] : 8'h00;
            out_fmt_q  <= hold_q ? rx_fmt_q[2:0]
                                 : bulk_port_pkg::FMT_IDLE;
        end
    end

    // In mode D the receive pins stay idle and the shared bus turns round.
    assign O_RECEIVE_BYTE_BUS    = mode_d ? 8'h00 : out_byte_q;
    assign O_OUTPUT_FORMAT_BUS   = mode_d ? bulk_port_pkg::FMT_IDLE
                                          : out_fmt_q;
    assign O_INPUT_BYTE_BUS      = out_byte_q;
    assign O_INPUT_FORMAT_BUS    = out_fmt_q;
    assign O_INPUT_BYTE_BUS_OE   = mode_d && iq_s && oq_s;
    assign O_INPUT_FORMAT_BUS_OE = mode_d && iq_s && oq_s;
    assign O_DATA_AVAILABLE_FLAG = hold_q;

    // --------------------------------------------------------------------
    // Half-rate sampling clock and pin edge history
    // --------------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            half_q      <= 1'b0;
            iclk_prev_q <= 1'b0;
            oclk_prev_q <= 1'b0;
        end else if (I_CLK_EN) begin
            half_q      <= !half_q;
            iclk_prev_q <= iclk_s;
            oclk_prev_q <= oclk_s;
        end
    end

    assign O_STATUS_PIN_ZERO  = half_q && route_q[bulk_port_pkg::ROUTE_STATUS_PIN_ZERO];
    assign O_STATUS_PIN_THREE = half_q && route_q[bulk_port_pkg::ROUTE_STATUS_PIN_THREE];

    // --------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // --------------------------------------------------------------------
    wire ap_valid = I_HSEL && I_HTRANS[1] && I_HREADY;
    wire [7:0] ap_addr = I_HADDR[7:0];
    wire [31:0] status_w = {25'h0, mode, 1'b0, tx_have_q,
                            hold_q, O_WRITE_FULL_FLAG};
    wire [31:0] rd_mux =
        (ap_addr == bulk_port_pkg::ADDR_CTRL)     ? {26'h0, ctrl_q} :
        (ap_addr == bulk_port_pkg::ADDR_STATUS)   ? status_w :
        (ap_addr == bulk_port_pkg::ADDR_CLKROUTE) ? {30'h0, route_q} :
                                                    32'h0;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            dph_wr_q   <= 1'b0;
            dph_addr_q <= 8'h00;
            rdata_q    <= 32'h0;
        end else if (I_CLK_EN) begin
            dph_wr_q   <= ap_valid && I_HWRITE;
            dph_addr_q <= ap_addr;
            if (ap_valid && !I_HWRITE) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_q  <= bulk_port_pkg::CTRL_RST;
            route_q <= bulk_port_pkg::ROUTE_RST;
        end else if (I_CLK_EN && dph_wr_q) begin
            if (dph_addr_q == bulk_port_pkg::ADDR_CTRL) begin
                ctrl_q <= I_HWDATA[5:0];
            end
            if (dph_addr_q == bulk_port_pkg::ADDR_CLKROUTE) begin
                route_q <= I_HWDATA[1:0];
            end
        end
    end

    assign O_HRDATA    = rdata_q;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP     = 1'b0;

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    a_full_on_boundary: assert property (
        $rose(wfull_q) |-> $past(wcnt_q) == 2'h0)
        else $error("write-full rose inside a quadlet");
    a_refuse_when_full: assert property (
        wfull_q && wr_req |=> $stable(wcnt_q) && $stable(wquad_q))
        else $error("byte taken while write-full stood");
    a_mode_c_no_full: assert property (
        mode_c |-> !O_WRITE_FULL_FLAG)
        else $error("write-full driven in mode C");
    a_quad_packed: assert property (
        wr_done |=> tx_have_q && tx_quad_q[31:24] == $past(ibyte_s))
        else $error("completed quadlet not handed on");
    a_pop_gives_avail: assert property (
        O_RX_POP |=> O_DATA_AVAILABLE_FLAG [*2])
        else $error("holding register load not flagged");
    a_idle_format: assert property (
        !hold_q && I_CLK_EN |=> out_fmt_q == bulk_port_pkg::FMT_IDLE)
        else $error("idle format missing with nothing held");
    a_mode_b_push: assert property (
        mode == bulk_port_pkg::MODE_B && out_rise && hold_q && !O_RX_POP
        |-> rd_take)
        else $error("mode B byte not pushed on port clock");
    a_mode_c_spacing: assert property (
        mode_c && rd_take |-> rgap_q >= bulk_port_pkg::GAP_EDGES)
        else $error("mode C reads too close together");
    a_mode_d_turn: assert property (
        O_INPUT_BYTE_BUS_OE |-> mode_d && oq_s && !wr_take)
        else $error("shared bus driven outside a mode D read");
    a_stat_route: assert property (
        route_q[bulk_port_pkg::ROUTE_STATUS_PIN_ZERO] && I_CLK_EN
        |=> O_STATUS_PIN_ZERO != $past(O_STATUS_PIN_ZERO))
        else $error("sampling clock not toggling on status pin");

    c_quad_push:   cover property (O_TX_WR);
    c_mode_b_read: cover property (rd_b && rd_take);
    c_mode_c_wr:   cover property (mode_c && wr_take);
    c_mode_d_read: cover property (rd_d && rd_last);

endmodule : bulk_byte_port

// ---- design/pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_en,
    // Data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second one.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q    <= '0;
        end else if (i_en) begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end

endmodule : pin_sync

// ---- shared/bulk_port_pkg.sv ----
// Operation
// - Mode B: input bus writes, receive bus reads, both at once.
// - Mode B ignores the output qualifier, pushes each received byte out.
// - Mode C resynchronises both byte ports to the applied port clocks.
// - Register 30h routes the half-rate sampling clock to a status pin.
// - Mode C reads and writes at most once every four port clock edges.
// - Mode C drives no write-full flag.
// - Mode C carries cells only; format top bit marks first byte.
// - Mode D is half duplex, reads and writes share the input byte bus.
// - Mode D: input qualifier enables, output qualifier sets direction.
// - Mode D flags write-full when full, data-available when bytes wait.
// - Write-full rises only between quadlets; bytes refused while high.
// - Each written byte's format passes through; mode C marks first or continuing cell bytes.
// - Modes A, B show read bytes with format; A advances on qualifier.
// - Data-available is high while the holding register has a quadlet.
// - Mode C read data stands at the edge after the qualifier rises.
// - Format codes: 000 reserved through 111 last asynchronous byte.
// - Mode D with enable active, direction high reads and low writes.
// - Mode fields: A 000/00, B 000/01, C 101/11, D 001/00.
package bulk_port_pkg;

    // --------------------------------------------------------------------
    // Format codes
    // --------------------------------------------------------------------
    localparam logic [2:0] FMT_RSVD       = 3'h0;
    localparam logic [2:0] FMT_CELL       = 3'h1;
    localparam logic [2:0] FMT_ISO        = 3'h2;
    localparam logic [2:0] FMT_ASYNC      = 3'h3;
    localparam logic [2:0] FMT_IDLE       = 3'h4;
    localparam logic [2:0] FMT_FIRST      = 3'h5;
    localparam logic [2:0] FMT_ISO_LAST   = 3'h6;
    localparam logic [2:0] FMT_ASYNC_LAST = 3'h7;

    // --------------------------------------------------------------------
    // Mode fields and modes
    // --------------------------------------------------------------------
    localparam logic [2:0] IMODE_AB = 3'h0;
    localparam logic [2:0] IMODE_C  = 3'h5;
    localparam logic [2:0] IMODE_D  = 3'h1;
    localparam logic [1:0] OMODE_A  = 2'h0;
    localparam logic [1:0] OMODE_B  = 2'h1;
    localparam logic [1:0] OMODE_C  = 2'h3;
    localparam logic [1:0] OMODE_D  = 2'h0;

    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_A,
        MODE_B,
        MODE_C,
        MODE_D
    } mode_e;

    // --------------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_CLKROUTE = 8'h30;
    localparam int          CTRL_IMODE    = 0;
    localparam int          CTRL_OMODE    = 4;
    localparam int          ROUTE_STATUS_PIN_ZERO   = 0;
    localparam int          ROUTE_STATUS_PIN_THREE   = 1;
    localparam int          ST_WFULL      = 0;
    localparam int          ST_AVAIL      = 1;
    localparam int          ST_TXPEND     = 2;
    localparam int          ST_MODE       = 4;
    localparam logic [5:0]  CTRL_RST      = 6'h00;
    localparam logic [1:0]  ROUTE_RST     = 2'h0;

    // --------------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------------
    // Port clock edges that must pass between two mode C transfers.
    localparam logic [2:0] GAP_EDGES = 3'h3;
    localparam logic [1:0] BYTE_LAST = 2'h3;
    localparam int         SYNC_W    = 15;

endpackage : bulk_port_pkg

// ---- verification/host_model.sv ----
`timescale 1ns/1ns
module host_model (
    // Core clock
    input  wire logic i_clk,
    // Host pins
    output logic       o_iclk,
    output logic       o_oclk,
    output logic       o_iq,
    output logic       o_oq,
    output logic [7:0] o_byte,
    output logic [2:0] o_fmt
);
    initial begin
        o_iclk = 1'b0;
        o_oclk = 1'b0;
        o_iq   = 1'b0;
        o_oq   = 1'b0;
        o_byte = 8'h00;
        o_fmt  = 3'h4;
    end
    // Port clocks share one slow rate and stand still between pulses.
    task automatic pulse(input logic o);
        repeat (4) @(posedge i_clk);
        if (o) o_oclk <= 1'b1;
        else o_iclk <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_oclk <= 1'b0;
        o_iclk <= 1'b0;
    endtask : pulse
    task automatic wr(input logic [7:0] b, input logic [2:0] f, input int g);
        @(posedge i_clk);
        for (int i = 0; i < g; i++) pulse(1'b0);
        o_byte <= b;
        o_fmt  <= f;
        o_iq   <= 1'b1;
        pulse(1'b0);
        o_iq   <= 1'b0;
        // Released bus shows the inverse so stale data never looks valid.
        o_byte <= ~b;
        o_fmt  <= ~f;
    endtask : wr
    task automatic rd(input logic q);
        @(posedge i_clk);
        o_oq <= q;
        pulse(1'b1);
        o_oq <= 1'b0;
        // Returns one edge late so the advanced byte has settled.
        @(posedge i_clk);
    endtask : rd
    // Mode D read: enable and direction high over one input clock pulse.
    task automatic rdd();
        @(posedge i_clk);
        o_iq <= 1'b1;
        o_oq <= 1'b1;
        pulse(1'b0);
        o_iq <= 1'b0;
        o_oq <= 1'b0;
        @(posedge i_clk);
    endtask : rdd
endmodule : host_model

// ---- verification/test_bulk_byte_port.sv ----
`timescale 1ns/1ns
module test_bulk_byte_port;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rxq = 32'hddccbbaa;
    logic [1:0]  htrans = 2'h0;
    logic tx_full = 1'b0, rx_valid = 1'b0, rdy, wfull, avail, st0, txwr, pop;
    logic iclk, oclk, iq, oq, st3;
    logic [7:0]  hb, rbyte, dbyte;
    logic [2:0]  hf, ofmt, dfmt;
    logic [31:0] hrdata, txq, quad_q, r;
    logic [11:0] txf, fmt_q;
    int fails = 0, compares = 0, wr_cnt = 0;
    localparam logic [11:0] CF = {3'h1, 3'h1, 3'h1, 3'h5};
    always #20 clk = ~clk;
    always @(posedge clk) if (txwr === 1'b1) begin
        wr_cnt <= wr_cnt + 1;
        quad_q <= txq;
        fmt_q  <= txf;
    end
    bulk_byte_port bulk_byte_port_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_CLK_EN(1'b1), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(rdy),
        .O_HRDATA(hrdata), .O_HREADYOUT(rdy), .O_HRESP(),
        .I_INPUT_PORT_CLOCK(iclk), .I_OUTPUT_PORT_CLOCK(oclk),
        .I_INPUT_QUALIFIER(iq), .I_OUTPUT_QUALIFIER(oq),
        .I_INPUT_BYTE_BUS(hb), .O_INPUT_BYTE_BUS(dbyte),
        .O_INPUT_BYTE_BUS_OE(),
        .I_INPUT_FORMAT_BUS(hf), .O_INPUT_FORMAT_BUS(dfmt),
        .O_INPUT_FORMAT_BUS_OE(), .O_RECEIVE_BYTE_BUS(rbyte),
        .O_OUTPUT_FORMAT_BUS(ofmt), .O_WRITE_FULL_FLAG(wfull),
        .O_DATA_AVAILABLE_FLAG(avail), .O_STATUS_PIN_ZERO(st0),
        .O_STATUS_PIN_THREE(st3), .O_TX_WR(txwr), .O_TX_QUAD(txq),
        .O_TX_FMT(txf), .I_TX_FULL(tx_full), .I_RX_VALID(rx_valid),
        .I_RX_QUAD(rxq), .I_RX_FMT(CF), .O_RX_POP(pop));
    host_model host_model_inst (.i_clk(clk), .o_iclk(iclk), .o_oclk(oclk),
        .o_iq(iq), .o_oq(oq), .o_byte(hb), .o_fmt(hf));
    task automatic stop_test();
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        r = hrdata;
    endtask : ahb
    // Four bytes, first one marked with f0, the rest with f1.
    task automatic wr4(input logic [7:0] b, input int g, input logic [2:0] f0,
                       input logic [2:0] f1);
        for (int i = 0; i < 4; i++) host_model_inst.wr(b + i, i ? f1 : f0, g);
        repeat (6) @(posedge clk);
    endtask : wr4
    task automatic t_regs();
        ahb(1'b0, 32'h4, 32'h0);
        chk("mode", r[6:4], 3'h1);
        ahb(1'b0, 32'h10, 32'h0);
        chk("unmapped", r, 32'h0);
        ahb(1'b1, 32'h30, 32'h2);
        @(negedge clk) r[0] = st3;
        @(negedge clk) chk("status_pin_three", st3, !r[0]);
        chk("status_pin_zero", st0, 1'b0);
        @(posedge clk);
        ahb(1'b1, 32'h30, 32'h1);
        ahb(1'b0, 32'h30, 32'h0);
        chk("route", r, 32'h1);
        @(negedge clk) r[0] = st0;
        @(negedge clk) chk("status_pin_zero", st0, !r[0]);
    endtask : t_regs
    task automatic t_full();
        tx_full <= 1'b1;
        wr4(8'h21, 0, 3'h5, 3'h1);
        chk("wfull", wfull, 1'b1);
        host_model_inst.wr(8'h55, 3'h1, 0);
        tx_full <= 1'b0;
        wr4(8'h61, 0, 3'h5, 3'h1);
        chk("quad", quad_q, 32'h64636261);
        chk("count", wr_cnt, 2);
        chk("wfull", wfull, 1'b0);
    endtask : t_full
    task automatic t_read(input logic mb);
        int k;
        rx_valid <= 1'b1;
        k = 0;
        do @(negedge clk); while (pop !== 1'b1 && ++k < 50);
        chk("pop", pop, 1'b1);
        @(posedge clk) rx_valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("avail", avail, 1'b1);
        chk("ofmt", ofmt, 3'h5);
        host_model_inst.rd(1'b0);
        k = mb;
        chk("rbyte", rbyte, rxq[8*k +: 8]);
        while (k < 3) begin
            host_model_inst.rd(1'b1);
            k++;
            chk("rbyte", rbyte, rxq[8*k +: 8]);
        end
        host_model_inst.rd(1'b1);
        chk("avail", avail, 1'b0);
        chk("ofmt", ofmt, 3'h4);
    endtask : t_read
    task automatic t_modec();
        ahb(1'b1, 32'h0, 32'h35);
        ahb(1'b0, 32'h4, 32'h0);
        chk("mode", r[6:4], 3'h3);
        tx_full <= 1'b1;
        repeat (4) @(posedge clk);
        chk("wfull", wfull, 1'b0);
        tx_full <= 1'b0;
        wr4(8'h71, 3, 3'h4, 3'h0);
        chk("quad", quad_q, 32'h74737271);
        chk("fmt", fmt_q, CF);
        rx_valid <= 1'b1;
        @(posedge clk) rx_valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("rbyte", rbyte, rxq[7:0]);
        for (int i = 1; i < 4; i++) begin
            repeat (3) host_model_inst.rd(1'b0);
            host_model_inst.rd(1'b1);
            chk("rbyte", rbyte, rxq[8*i +: 8]);
        end
        repeat (3) host_model_inst.rd(1'b0);
        host_model_inst.rd(1'b1);
        chk("avail", avail, 1'b0);
    endtask : t_modec
    task automatic t_moded();
        ahb(1'b1, 32'h0, 32'h1);
        ahb(1'b0, 32'h4, 32'h0);
        chk("mode", r[6:4], 3'h4);
        wr4(8'h81, 0, 3'h5, 3'h1);
        chk("quad", quad_q, 32'h84838281);
        rx_valid <= 1'b1;
        @(posedge clk) rx_valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("avail", avail, 1'b1);
        chk("ofmt", ofmt, 3'h4);
        for (int i = 0; i < 4; i++) begin
            chk("dbyte", dbyte, rxq[8*i +: 8]);
            chk("dfmt", dfmt, CF[3*i +: 3]);
            host_model_inst.rdd();
        end
        chk("avail", avail, 1'b0);
        chk("rbyte", rbyte, 8'h00);
    endtask : t_moded
    initial begin
        #400000;
        fails++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("ofmt", ofmt, 3'h4);
        t_regs();
        wr4(8'h11, 0, 3'h5, 3'h1);
        chk("quad", quad_q, 32'h14131211);
        chk("fmt", fmt_q, CF);
        t_full();
        t_read(1'b0);
        ahb(1'b1, 32'h0, 32'h10);
        t_read(1'b1);
        t_modec();
        t_moded();
        stop_test();
    end
endmodule : test_bulk_byte_port
